//--- src/rtcrac_cfg.svh
// offsets, bit positions, reset values and codes of the rtc run/alarm control block
`ifndef RTCRAC_CFG_SVH
`define RTCRAC_CFG_SVH
// register indices; byte address is four times the index
`define RTCRAC_IDX_RUN     34'h040044f5d
`define RTCRAC_IDX_ALM     34'h040044f5e
`define RTCRAC_RST_RUN     8'h00
`define RTCRAC_RST_ALM     8'h00
// run control fields
`define RTCRAC_B_RUN_EN    7
`define RTCRAC_B_PULSE_EN  5
`define RTCRAC_B_HOUR_FMT  3
`define RTCRAC_B_PSEL_HI   2
`define RTCRAC_B_PSEL_LO   0
// alarm and wait control fields
`define RTCRAC_B_ALM_EN    7
`define RTCRAC_B_ALM_IE    6
`define RTCRAC_B_ALM_FLG   4
`define RTCRAC_B_PER_FLG   3
`define RTCRAC_B_HOLD_ST   1
`define RTCRAC_B_HOLD_REQ  0
// periodic select codes
`define RTCRAC_PSEL_NONE   3'h0
`define RTCRAC_PSEL_HALF   3'h1
`define RTCRAC_PSEL_SEC    3'h2
`define RTCRAC_PSEL_MIN    3'h3
`define RTCRAC_PSEL_HOUR   3'h4
`define RTCRAC_PSEL_DAY    3'h5
// bus answers
`define RTCRAC_RESP_OKAY   2'h0
`define RTCRAC_RESP_SLVERR 2'h2
`endif

//--- src/rtcrac_pkg.sv
// types shared by the rtc run/alarm control block
package rtcrac_pkg;
  typedef logic [5:0] rtcrac_hour_t;
  typedef logic [2:0] rtcrac_psel_t;
  typedef enum logic [1:0] {
    RTCRAC_WR_IDLE,
    RTCRAC_WR_RESP
  } rtcrac_wr_st_t;
endpackage : rtcrac_pkg

//--- src/rtcrac_hour_conv.sv
// hour count conversion between 12-hour and 24-hour coding
module rtcrac_hour_conv (
  // hour in
  input  wire rtcrac_pkg::rtcrac_hour_t hour_in,
  input  wire logic                     to_24,
  // hour out
  output rtcrac_pkg::rtcrac_hour_t      hour_out
);
  import rtcrac_pkg::*;

  function automatic logic [4:0] bcd2bin(input logic [1:0] tens, input logic [3:0] ones);
    bcd2bin = 5'(tens) * 5'd10 + 5'(ones);
  endfunction : bcd2bin

  function automatic logic [5:0] bin2bcd(input logic [4:0] b);
    logic [4:0] r;
    r = b;
    if (b >= 5'd20) begin
      bin2bcd = {2'h2, 4'(r - 5'd20)};
    end else if (b >= 5'd10) begin
      bin2bcd = {2'h1, 4'(r - 5'd10)};
    end else begin
      bin2bcd = {2'h0, r[3:0]};
    end
  endfunction : bin2bcd

  logic [4:0] v12;
  logic [4:0] v24;
  logic [4:0] b;
  logic       pm;
  logic [5:0] enc;

  // 12-hour coding: bit5 is the afternoon mark, bits 4:0 hold 01..12 in bcd
  always_comb begin
    v12      = bcd2bin({1'b0, hour_in[4]}, hour_in[3:0]);
    v24      = bcd2bin(hour_in[5:4], hour_in[3:0]);
    b        = 5'h00;
    pm       = 1'b0;
    enc      = 6'h00;
    hour_out = hour_in;
    if (to_24) begin
      if (v12 == 5'd12) begin
        b = hour_in[5] ? 5'd12 : 5'd0;
      end else begin
        b = hour_in[5] ? 5'(v12 + 5'd12) : v12;
      end
      hour_out = bin2bcd(b);
    end else begin
      pm = (v24 >= 5'd12);
      b  = pm ? 5'(v24 - 5'd12) : v24;
      if (b == 5'd0) begin
        b = 5'd12;
      end
      enc      = bin2bcd(b);
      hour_out = {pm, enc[4:0]};
    end
  end
endmodule : rtcrac_hour_conv

//--- src/rtcrac_top.sv
// rtc run, hour format, periodic and alarm control with axi4-lite registers
//
// Implementation choice: the AXI4-Lite interface to the registers.
`include "rtcrac_cfg.svh"

// Notes on behaviour
// - run enable bit lets calendar count
// - pulse enable drives 1hz square output
// - pulse enable frozen while counter runs
// - no 1hz output while run enable bit clear
// - hour format bit picks 12/24 hour
// - format change converts current hour count
// - periodic select field picks interrupt interval
// - half and full second aligned to seconds
// - alarm enable bit gates alarm comparison
// - alarm irq enable gates alarm interrupt
// - alarm flag sets one count clock later
// - alarm flag cleared by zero write
// - hold request stops counters, status follows
// - periodic flag sets, zero write clears
// - periodic and alarm share one interrupt
module rtcrac_top #(
  parameter int AW = 12
) (
  // clock and reset
  input  wire logic                     mclk,
  input  wire logic                     rst,
  // axi4-lite write address and data
  input  wire logic [AW-1:0]            s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  // axi4-lite read
  input  wire logic [AW-1:0]            s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  // calendar counter events, same clock
  input  wire logic                     count_tick,
  input  wire logic                     sec_tick,
  input  wire logic                     half_tick,
  input  wire logic                     sec_zero,
  input  wire logic                     min_zero,
  input  wire logic                     hour_zero,
  input  wire logic                     day_one,
  input  wire logic                     alarm_hit,
  input  wire rtcrac_pkg::rtcrac_hour_t hour_now,
  // calendar control
  output logic                          count_enable,
  output logic                          counter_hold_status,
  output logic                          hour_format_select,
  output logic                          hour_load,
  output rtcrac_pkg::rtcrac_hour_t      hour_value,
  // pin and interrupt
  output logic                          one_hertz_pin,
  output logic                          rtc_interrupt
);
  import rtcrac_pkg::*;

  function automatic logic addr_hit(input logic [AW-1:0] a, input logic [33:0] idx);
    logic [33:0] byte_addr;
    byte_addr = {idx[31:0], 2'b00};
    addr_hit  = (a[AW-1:2] == byte_addr[AW-1:2]);
  endfunction : addr_hit

  // bus state
  rtcrac_wr_st_t wst_q, wst_d;
  logic          aw_have_q, aw_have_d;
  logic          w_have_q, w_have_d;
  logic [AW-1:0] waddr_q, waddr_d;
  logic [7:0]    wbyte_q, wbyte_d;
  logic          wlane_q, wlane_d;
  logic          awready_q, awready_d;
  logic          wready_q, wready_d;
  logic          bvalid_q, bvalid_d;
  logic [1:0]    bresp_q, bresp_d;
  logic          arready_q, arready_d;
  logic          rvalid_q, rvalid_d;
  logic [31:0]   rdata_q, rdata_d;
  logic [1:0]    rresp_q, rresp_d;
  logic          do_wr;
  logic          wr_run;
  logic          wr_alm;

  // control state
  logic          run_en_q, run_en_d;
  logic          pulse_en_q, pulse_en_d;
  logic          hfmt_q, hfmt_d;
  rtcrac_psel_t  psel_q, psel_d;
  logic          alm_en_q, alm_en_d;
  logic          alm_ie_q, alm_ie_d;
  logic          alm_flg_q, alm_flg_d;
  logic          per_flg_q, per_flg_d;
  logic          hold_req_q, hold_req_d;
  logic          hold_st_q, hold_st_d;
  logic          alm_pend_q, alm_pend_d;
  logic          irq_q, irq_d;
  logic          pin_q, pin_d;
  logic          cnt_en_q, cnt_en_d;
  logic          hload_q, hload_d;
  rtcrac_hour_t  hval_q, hval_d;
  logic          per_evt;
  logic          alm_set;
  logic [7:0]    run_rd;
  logic [7:0]    alm_rd;
  rtcrac_hour_t  hour_conv;

  rtcrac_hour_conv u_conv (
    .hour_in  (hour_now),
    .to_24    (wbyte_q[`RTCRAC_B_HOUR_FMT]),
    .hour_out (hour_conv)
  );

  assign run_rd = {run_en_q, 1'b0, pulse_en_q, 1'b0, hfmt_q, psel_q};
  assign alm_rd = {alm_en_q, alm_ie_q, 1'b0, alm_flg_q, per_flg_q, 1'b0, hold_st_q, hold_req_q};

  // bus slave: address and data taken in either order, response after both
  always_comb begin
    wst_d     = wst_q;
    aw_have_d = aw_have_q;
    w_have_d  = w_have_q;
    waddr_d   = waddr_q;
    wbyte_d   = wbyte_q;
    wlane_d   = wlane_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    rvalid_d  = rvalid_q;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    do_wr     = 1'b0;
    if (s_axi_awvalid && awready_q) begin
      aw_have_d = 1'b1;
      waddr_d   = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_q) begin
      w_have_d = 1'b1;
      wbyte_d  = s_axi_wdata[7:0];
      wlane_d  = s_axi_wstrb[0];
    end
    case (wst_q)
      RTCRAC_WR_IDLE: begin
        if (aw_have_q && w_have_q) begin
          do_wr     = 1'b1;
          aw_have_d = 1'b0;
          w_have_d  = 1'b0;
          bvalid_d  = 1'b1;
          bresp_d   = (addr_hit(waddr_q, `RTCRAC_IDX_RUN) || addr_hit(waddr_q, `RTCRAC_IDX_ALM))
                      ? `RTCRAC_RESP_OKAY : `RTCRAC_RESP_SLVERR;
          wst_d     = RTCRAC_WR_RESP;
        end
      end
      RTCRAC_WR_RESP: begin
        if (s_axi_bready) begin
          bvalid_d = 1'b0;
          wst_d    = RTCRAC_WR_IDLE;
        end
      end
      default: begin
        wst_d = RTCRAC_WR_IDLE;
      end
    endcase
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (s_axi_arvalid && arready_q) begin
      rvalid_d = 1'b1;
      rresp_d  = `RTCRAC_RESP_OKAY;
      if (addr_hit(s_axi_araddr, `RTCRAC_IDX_RUN)) begin
        rdata_d = {24'h000000, run_rd};
      end else if (addr_hit(s_axi_araddr, `RTCRAC_IDX_ALM)) begin
        rdata_d = {24'h000000, alm_rd};
      end else begin
        rdata_d = 32'h00000000;
        rresp_d = `RTCRAC_RESP_SLVERR;
      end
    end
    // ready withheld while a held item waits for its partner or its response
    awready_d = ~aw_have_d && (wst_d == RTCRAC_WR_IDLE) && ~do_wr;
    wready_d  = ~w_have_d && (wst_d == RTCRAC_WR_IDLE) && ~do_wr;
    arready_d = ~rvalid_d;
    wr_run    = do_wr && wlane_q && addr_hit(waddr_q, `RTCRAC_IDX_RUN);
    wr_alm    = do_wr && wlane_q && addr_hit(waddr_q, `RTCRAC_IDX_ALM);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      wst_q     <= RTCRAC_WR_IDLE;
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      waddr_q   <= '0;
      wbyte_q   <= 8'h00;
      wlane_q   <= 1'b0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `RTCRAC_RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h00000000;
      rresp_q   <= `RTCRAC_RESP_OKAY;
    end else begin
      wst_q     <= wst_d;
      aw_have_q <= aw_have_d;
      w_have_q  <= w_have_d;
      waddr_q   <= waddr_d;
      wbyte_q   <= wbyte_d;
      wlane_q   <= wlane_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
    end
  end

  // periodic event source, only while the run enable bit is set
  always_comb begin
    case (psel_q)
      `RTCRAC_PSEL_NONE: per_evt = 1'b0;
      `RTCRAC_PSEL_HALF: per_evt = sec_tick || half_tick;
      `RTCRAC_PSEL_SEC:  per_evt = sec_tick;
      `RTCRAC_PSEL_MIN:  per_evt = sec_tick && sec_zero;
      `RTCRAC_PSEL_HOUR: per_evt = sec_tick && sec_zero && min_zero;
      `RTCRAC_PSEL_DAY:  per_evt = sec_tick && sec_zero && min_zero && hour_zero;
      default:           per_evt = sec_tick && sec_zero && min_zero && hour_zero && day_one;
    endcase
    per_evt = per_evt && run_en_q;
  end

  // control and status registers
  always_comb begin
    run_en_d   = run_en_q;
    pulse_en_d = pulse_en_q;
    hfmt_d     = hfmt_q;
    psel_d     = psel_q;
    alm_en_d   = alm_en_q;
    alm_ie_d   = alm_ie_q;
    hold_req_d = hold_req_q;
    hold_st_d  = hold_st_q;
    hload_d    = 1'b0;
    hval_d     = hval_q;
    if (wr_run) begin
      run_en_d = wbyte_q[`RTCRAC_B_RUN_EN];
      if (!run_en_q) begin
        pulse_en_d = wbyte_q[`RTCRAC_B_PULSE_EN];
      end
      hfmt_d = wbyte_q[`RTCRAC_B_HOUR_FMT];
      psel_d = wbyte_q[`RTCRAC_B_PSEL_HI:`RTCRAC_B_PSEL_LO];
      if (wbyte_q[`RTCRAC_B_HOUR_FMT] != hfmt_q) begin
        hload_d = 1'b1;
        hval_d  = hour_conv;
      end
    end
    if (wr_alm) begin
      alm_en_d   = wbyte_q[`RTCRAC_B_ALM_EN];
      alm_ie_d   = wbyte_q[`RTCRAC_B_ALM_IE];
      hold_req_d = wbyte_q[`RTCRAC_B_HOLD_REQ];
    end
    // hold status follows the request at the next count clock
    if (count_tick) begin
      hold_st_d = hold_req_q;
    end
    // match caught now, flag raised one count clock later; dropped if enable clears
    alm_set    = alm_pend_q && count_tick && alm_en_q;
    alm_pend_d = alm_en_q && (alarm_hit || (alm_pend_q && !count_tick));
    // only a zero write clears a flag; a set in the same cycle wins
    alm_flg_d  = alm_set || (alm_flg_q && !(wr_alm && !wbyte_q[`RTCRAC_B_ALM_FLG]));
    per_flg_d  = per_evt || (per_flg_q && !(wr_alm && !wbyte_q[`RTCRAC_B_PER_FLG]));
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      run_en_q   <= 1'b0;
      pulse_en_q <= 1'b0;
      hfmt_q     <= 1'b0;
      psel_q     <= `RTCRAC_PSEL_NONE;
      alm_en_q   <= 1'b0;
      alm_ie_q   <= 1'b0;
      alm_flg_q  <= 1'b0;
      per_flg_q  <= 1'b0;
      hold_req_q <= 1'b0;
      hold_st_q  <= 1'b0;
      alm_pend_q <= 1'b0;
      hload_q    <= 1'b0;
      hval_q     <= 6'h00;
    end else begin
      run_en_q   <= run_en_d;
      pulse_en_q <= pulse_en_d;
      hfmt_q     <= hfmt_d;
      psel_q     <= psel_d;
      alm_en_q   <= alm_en_d;
      alm_ie_q   <= alm_ie_d;
      alm_flg_q  <= alm_flg_d;
      per_flg_q  <= per_flg_d;
      hold_req_q <= hold_req_d;
      hold_st_q  <= hold_st_d;
      alm_pend_q <= alm_pend_d;
      hload_q    <= hload_d;
      hval_q     <= hval_d;
    end
  end

  // outputs: pin, interrupt, counter control
  always_comb begin
    cnt_en_d = run_en_q && !hold_st_q;
    pin_d    = pin_q;
    if (!(run_en_q && pulse_en_q)) begin
      pin_d = 1'b0;
    end else if (sec_tick) begin
      pin_d = 1'b1;
    end else if (half_tick) begin
      pin_d = 1'b0;
    end
    // one shared line; the flags tell the source apart
    irq_d = irq_q;
    if (count_tick) begin
      irq_d = 1'b0;
    end
    if (per_evt || (alm_set && alm_ie_q)) begin
      irq_d = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt_en_q <= 1'b0;
      pin_q    <= 1'b0;
      irq_q    <= 1'b0;
    end else begin
      cnt_en_q <= cnt_en_d;
      pin_q    <= pin_d;
      irq_q    <= irq_d;
    end
  end

  assign s_axi_awready       = awready_q;
  assign s_axi_wready        = wready_q;
  assign s_axi_bvalid        = bvalid_q;
  assign s_axi_bresp         = bresp_q;
  assign s_axi_arready       = arready_q;
  assign s_axi_rvalid        = rvalid_q;
  assign s_axi_rdata         = rdata_q;
  assign s_axi_rresp         = rresp_q;
  assign count_enable        = cnt_en_q;
  assign counter_hold_status = hold_st_q;
  assign hour_format_select  = hfmt_q;
  assign hour_load           = hload_q;
  assign hour_value          = hval_q;
  assign one_hertz_pin       = pin_q;
  assign rtc_interrupt       = irq_q;
endmodule : rtcrac_top

//--- bench/rtcrac_props.sv
// concurrent checks on the ports of the rtc run/alarm control block
module rtcrac_props (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // bus handshakes
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // calendar events
  input wire logic count_tick,
  input wire logic sec_tick,
  input wire logic half_tick,
  // control, pin and interrupt
  input wire logic count_enable,
  input wire logic counter_hold_status,
  input wire logic hour_load,
  input wire logic one_hertz_pin,
  input wire logic rtc_interrupt
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  sequence s_wr_done;
    s_axi_bvalid && s_axi_bready;
  endsequence
  sequence s_rd_done;
    s_axi_rvalid && s_axi_rready;
  endsequence

  property p_wr_ready;
    s_wr_done |=> s_axi_awready;
  endproperty
  property p_rd_ready;
    s_rd_done |=> !s_axi_rvalid && s_axi_arready;
  endproperty
  property p_rd_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  property p_pin_rise;
    $rose(one_hertz_pin) |-> $past(sec_tick);
  endproperty
  property p_pin_fall;
    half_tick && !sec_tick |=> !one_hertz_pin;
  endproperty
  property p_hold_tick;
    $changed(counter_hold_status) |-> $past(count_tick);
  endproperty
  property p_hold_stop;
    counter_hold_status |=> !count_enable;
  endproperty
  // the interrupt may only end on a count clock, so it lasts until the next count clock after it rises
  property p_irq_fall;
    $fell(rtc_interrupt) |-> $past(count_tick);
  endproperty
  property p_irq_cause;
    $rose(rtc_interrupt) |-> $past(sec_tick || half_tick || count_tick);
  endproperty
  property p_hour_load;
    hour_load |-> ($past(s_axi_bvalid) || s_axi_bvalid) ##1 !hour_load;
  endproperty

  a_wr_ready: assert property (p_wr_ready) else $error("write ready not back in time");
  a_rd_ready: assert property (p_rd_ready) else $error("read ready not back in time");
  a_rd_answer: assert property (p_rd_answer) else $error("read data late");
  a_pin_rise: assert property (p_pin_rise) else $error("pin rose without second");
  a_pin_fall: assert property (p_pin_fall) else $error("pin high after half");
  a_hold_tick: assert property (p_hold_tick) else $error("hold moved off tick");
  a_hold_stop: assert property (p_hold_stop) else $error("count runs in hold");
  a_irq_fall: assert property (p_irq_fall) else $error("irq ended off tick");
  a_irq_cause: assert property (p_irq_cause) else $error("irq without event");
  a_hour_load: assert property (p_hour_load) else $error("stray hour load");
endmodule : rtcrac_props

bind rtcrac_top rtcrac_props u_props (
  .mclk, .rst, .s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .count_tick, .sec_tick, .half_tick,
  .count_enable, .counter_hold_status, .hour_load, .one_hertz_pin, .rtc_interrupt
);

//--- bench/rtcrac_tb.sv
// self-checking bench for the rtc run/alarm control block
`include "rtcrac_cfg.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import rtcrac_pkg::*;
  localparam logic [11:0] A_RUN = 12'(`RTCRAC_IDX_RUN << 2);
  localparam logic [11:0] A_ALM = 12'(`RTCRAC_IDX_ALM << 2);
  localparam logic [1:0]  OK    = `RTCRAC_RESP_OKAY;
  localparam logic [1:0]  ER    = `RTCRAC_RESP_SLVERR;
  typedef struct packed {
    logic [11:0] a;
    logic [7:0]  d;
    logic [3:0]  s;
    logic [1:0]  r;
    logic [7:0]  e;
  } rtcrac_row_t;
  logic         mclk;
  logic         rst = 1'b1;
  logic [11:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0]  s_axi_wdata = '0;
  logic [3:0]   s_axi_wstrb = '0;
  logic         count_tick = 1'b0, sec_tick = 1'b0, half_tick = 1'b0, alarm_hit = 1'b0;
  logic         sec_zero = 1'b0, min_zero = 1'b0, hour_zero = 1'b0, day_one = 1'b0;
  rtcrac_hour_t hour_now = '0;
  logic         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]   s_axi_bresp, s_axi_rresp;
  logic [31:0]  s_axi_rdata;
  logic         count_enable, counter_hold_status, hour_format_select, hour_load;
  rtcrac_hour_t hour_value;
  logic         one_hertz_pin, rtc_interrupt, ex;
  logic [1:0]   tick_q = '0;
  int           mismatches = 0;
  int           samples_checked = 0;
  int           n, need;
  // awkward cases: strobe off, flag writes of one, pulse enable locked, unmapped
  rtcrac_row_t  rows [8] = '{
    '{A_RUN, 8'h2a, 4'h1, OK, 8'h2a}, '{A_ALM, 8'hd8, 4'h1, OK, 8'hc0},
    '{A_ALM, 8'hc1, 4'h0, OK, 8'hc0}, '{A_ALM, 8'h00, 4'h1, OK, 8'h00},
    '{A_RUN, 8'hff, 4'h1, OK, 8'haf}, '{A_RUN, 8'h0f, 4'h1, OK, 8'h2f},
    '{A_RUN, 8'h00, 4'h1, OK, 8'h00}, '{12'h000, 8'h5a, 4'h1, ER, 8'h00}};

  rtcrac_top dut (
    .mclk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .count_tick, .sec_tick, .half_tick,
    .sec_zero, .min_zero, .hour_zero, .day_one, .alarm_hit, .hour_now, .count_enable,
    .counter_hold_status, .hour_format_select, .hour_load, .hour_value,
    .one_hertz_pin, .rtc_interrupt
  );

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // count clock of four bus cycles keeps the alarm and hold waits short
  always @(posedge mclk) begin
    tick_q <= tick_q + 2'h1;
    count_tick <= (tick_q == 2'h3);
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic chk_pin(input logic g, input logic e);
    chk(32'(g), 32'(e));
  endtask : chk_pin

  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // no cycle count assumed; only the watchdog ends a lost answer
    do begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(er));
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [1:0] er);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, {24'h0, e});
    chk(32'(s_axi_rresp), 32'(er));
  endtask : rd

  task automatic pulse(input logic [2:0] w);
    @(posedge mclk);
    {alarm_hit, half_tick, sec_tick} <= w;
    @(posedge mclk);
    {alarm_hit, half_tick, sec_tick} <= 3'h0;
    #1;
  endtask : pulse

  task automatic hour(input logic [7:0] f, input rtcrac_hour_t h, input rtcrac_hour_t e);
    hour_now <= h;
    wr(A_RUN, f, 4'h1, OK);
    for (n = 0; n < 4 && hour_load !== 1'b1; n++) @(posedge mclk);
    chk_pin(hour_load, 1'b1);
    chk(32'(hour_value), 32'(e));
    chk_pin(hour_format_select, f[3]);
  endtask : hour

  task automatic do_reset;
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
  endtask : do_reset

  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize

  // the run takes under a thousand cycles; this leaves a wide margin
  initial begin
    #100us;
    mismatches++;
    summarize();
  end

  initial begin
    do_reset();
    rd(A_RUN, 8'h00, OK);
    rd(A_ALM, 8'h00, OK);
    for (int r = 0; r < 8; r++) begin
      wr(rows[r].a, rows[r].d, rows[r].s, rows[r].r);
      rd(rows[r].a, rows[r].e, rows[r].r);
    end
    for (int c = 0; c < 8; c++) begin
      wr(A_RUN, 8'h80 | 8'(c), 4'h1, OK);
      for (int i = 0; i < 6; i++) begin
        {day_one, hour_zero, min_zero, sec_zero} <= 4'((1 << i) - 1);
        need = c >= 6 ? 4 : (c < 3 ? 0 : c - 2);
        ex = (i == 5) ? (c == 1) : (c != 0 && i >= need);
        pulse(i == 5 ? 3'h2 : 3'h1);
        chk_pin(rtc_interrupt, ex);
        rd(A_ALM, {4'h0, ex, 3'h0}, OK);
        wr(A_ALM, 8'h00, 4'h1, OK);
      end
    end
    // pulse enable only takes while stopped, so stop first
    wr(A_RUN, 8'h00, 4'h1, OK);
    wr(A_RUN, 8'ha0, 4'h1, OK);
    pulse(3'h1);
    chk_pin(one_hertz_pin, 1'b1);
    chk_pin(count_enable, 1'b1);
    pulse(3'h2);
    chk_pin(one_hertz_pin, 1'b0);
    wr(A_RUN, 8'h00, 4'h1, OK);
    rd(A_RUN, 8'h20, OK);
    pulse(3'h1);
    chk_pin(one_hertz_pin, 1'b0);
    chk_pin(count_enable, 1'b0);
    wr(A_RUN, 8'h00, 4'h1, OK);
    wr(A_RUN, 8'h80, 4'h1, OK);
    pulse(3'h4);
    repeat (8) @(posedge mclk);
    rd(A_ALM, 8'h00, OK);
    wr(A_ALM, 8'h80, 4'h1, OK);
    pulse(3'h4);
    for (n = 0; n < 8 && rtc_interrupt !== 1'b1; n++) @(posedge mclk);
    chk_pin(rtc_interrupt, 1'b0);
    rd(A_ALM, 8'h90, OK);
    wr(A_ALM, 8'h90, 4'h1, OK);
    rd(A_ALM, 8'h90, OK);
    wr(A_ALM, 8'h80, 4'h1, OK);
    rd(A_ALM, 8'h80, OK);
    wr(A_ALM, 8'hc0, 4'h1, OK);
    pulse(3'h4);
    for (n = 0; n < 6 && rtc_interrupt !== 1'b1; n++) @(posedge mclk);
    chk_pin(rtc_interrupt, 1'b1);
    rd(A_ALM, 8'hd0, OK);
    wr(A_ALM, 8'h01, 4'h1, OK);
    for (n = 0; n < 6 && counter_hold_status !== 1'b1; n++) @(posedge mclk);
    #1;
    chk_pin(counter_hold_status, 1'b1);
    rd(A_ALM, 8'h03, OK);
    chk_pin(count_enable, 1'b0);
    hour(8'h88, 6'h32, 6'h12);
    hour(8'h80, 6'h13, 6'h21);
    hour(8'h88, 6'h12, 6'h00);
    wr(A_ALM, 8'h00, 4'h1, OK);
    for (n = 0; n < 8 && count_enable !== 1'b1; n++) @(posedge mclk);
    chk_pin(count_enable, 1'b1);
    do_reset();
    rd(A_RUN, 8'h00, OK);
    rd(A_ALM, 8'h00, OK);
    summarize();
  end
endmodule : testbench
